// ==== src/mmd_decoder.sv ====
// Purpose: Program, external and internal data decoder for the MCU.
// Assumes: Memory arrays sit outside; strobes are registered one cycle.
// Notes: Config blocks and register window answer reads from flops.
`timescale 1ns/1ps
module mmd_decoder (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // External MCU mode strap pin
   input wire logic i_ext_mcu_pin,
   // Program fetch
   input wire logic i_pgm_rd,
   input wire logic [15:0] i_pgm_addr,
   output logic o_pgm_rom_en,
   output logic o_pgm_cram_en,
   output logic [12:0] o_pgm_mem_addr,
   // External data access
   input wire logic i_x_rd,
   input wire logic i_x_wr,
   input wire logic [15:0] i_x_addr,
   input wire logic [7:0] i_x_wdata,
   output logic [7:0] o_x_rdata,
   output logic o_x_rvalid,
   // Code RAM data port
   output logic o_cram_we,
   output logic o_cram_re,
   output logic [12:0] o_cram_addr,
   output logic [7:0] o_cram_wdata,
   // Buffer and setup RAM port
   output logic o_xram_we,
   output logic o_xram_re,
   output logic o_xram_setup,
   output logic [10:0] o_xram_addr,
   output logic [7:0] o_xram_wdata,
   // Internal data access
   input wire logic i_i_rd,
   input wire logic i_i_wr,
   input wire logic i_i_indirect,
   input wire logic [7:0] i_i_addr,
   output logic o_iram_en,
   output logic o_sfr_en,
   output logic o_i_we,
   output logic [7:0] o_i_addr,
   // Buffer manager count writes
   input wire logic i_ubm_wr,
   input wire logic i_ubm_out,
   input wire logic [2:0] i_ubm_ep,
   input wire logic i_ubm_y,
   input wire logic [7:0] i_ubm_count,
   // DMA count writes
   input wire logic i_dma_wr,
   input wire logic i_dma_out,
   input wire logic [2:0] i_dma_ep,
   input wire logic i_dma_y,
   input wire logic [7:0] i_dma_count,
   // Endpoint view
   input wire logic i_view_out,
   input wire logic [2:0] i_view_ep,
   output logic [7:0] o_view_cfg,
   output logic [7:0] o_view_size,
   output logic [7:0] o_view_x_count,
   output logic [7:0] o_view_y_count,
   output logic [15:0] o_view_x_addr,
   output logic [15:0] o_view_y_addr,
   output logic o_view_iso,
   output logic [7:0] o_view_ring_len,
   // Mode status
   output logic o_code_space_select,
   output logic o_ext_mode
);
   import mmd_pkg::*;

   logic ext_s1_reg;
   logic ext_s2_reg;
   logic ext_s3_reg;
   logic ext_reg;
   logic [7:0] csr_reg [CSR_BYTES];
   logic css;
   logic first_reg;
   logic [15:0] xa;
   mmd_region_type rg;
   logic [15:0] ofs;
   logic [6:0] cfg_idx;
   logic [6:0] csr_idx;
   logic [7:0] cfg_rdata;
   logic cfg_wr;
   logic pgm_rom;
   logic pgm_cram;

   assign css = csr_reg[CSR_MEMCFG_IDX][CSS_BIT];
   assign o_code_space_select = css;
   assign o_ext_mode = ext_reg;

   // Strap sync: a change counts once stages two and three agree
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_s3_reg <= 1'b0;
         ext_reg <= 1'b0;
      end else begin
         ext_s1_reg <= i_ext_mcu_pin;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
         if (ext_s2_reg == ext_s3_reg) begin
            ext_reg <= ext_s3_reg;
         end
      end
   end

   // Marks the first cycle after reset release for checking
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   // Partial decode: only A0-A10 reach us from an external MCU
   assign xa = ext_reg ? {EXT_HI_BITS, i_x_addr[10:0]} : i_x_addr;

   // Region decode; code RAM hides from data space after boot
   always_comb begin
      rg = RG_NONE;
      ofs = 16'h0000;
      if (!ext_reg && !css && in_rng(xa, CRAM_BASE, CRAM_SIZE)) begin
         rg = RG_CRAM;
         ofs = xa - CRAM_BASE;
      end else if (in_rng(xa, BUF_BASE, BUF_SIZE)) begin
         rg = RG_BUF;
         ofs = xa - BUF_BASE;
         // Setup buffer stays hidden from an external MCU
      end else if (!ext_reg && in_rng(xa, SETUP_BASE, SETUP_SIZE)) begin
         rg = RG_SETUP;
         ofs = xa - SETUP_BASE;
      end else if (in_rng(xa, CFG_BASE, CFG_SIZE)) begin
         rg = RG_CFG;
         ofs = xa - CFG_BASE;
      end else if (in_rng(xa, CSR_BASE, CSR_SIZE)) begin
         rg = RG_CSR;
         ofs = xa - CSR_BASE;
      end
   end

   assign cfg_idx = ofs[6:0];
   assign csr_idx = ofs[6:0];
   assign cfg_wr = i_x_wr && (rg == RG_CFG);

   // Register window in flops; byte 0 bit 0 selects code space
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < CSR_BYTES; i++) begin
            csr_reg[i] <= 8'h00;
         end
      end else if (i_x_wr && rg == RG_CSR) begin
         csr_reg[csr_idx] <= i_x_wdata;
      end
   end

   // Code RAM data port; writes can only form in boot mode
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cram_we <= 1'b0;
         o_cram_re <= 1'b0;
         o_cram_addr <= 13'h0000;
         o_cram_wdata <= 8'h00;
      end else begin
         // Silent drop: no fault flag exists by design
         o_cram_we <= i_x_wr && (rg == RG_CRAM) && !css;
         o_cram_re <= i_x_rd && (rg == RG_CRAM);
         o_cram_addr <= ofs[12:0];
         o_cram_wdata <= i_x_wdata;
      end
   end

   // Endpoint buffer and setup RAM port
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_xram_we <= 1'b0;
         o_xram_re <= 1'b0;
         o_xram_setup <= 1'b0;
         o_xram_addr <= 11'h000;
         o_xram_wdata <= 8'h00;
      end else begin
         o_xram_we <= i_x_wr && (rg == RG_BUF || rg == RG_SETUP);
         o_xram_re <= i_x_rd && (rg == RG_BUF || rg == RG_SETUP);
         o_xram_setup <= (rg == RG_SETUP);
         o_xram_addr <= ofs[10:0];
         o_xram_wdata <= i_x_wdata;
      end
   end

   // Flop-held regions and unmapped holes answer here one cycle later
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_x_rdata <= 8'h00;
         o_x_rvalid <= 1'b0;
      end else begin
         // Unmapped reads answer zero so the core never waits
         o_x_rvalid <= i_x_rd && (rg == RG_CFG || rg == RG_CSR ||
                                  rg == RG_NONE);
         if (rg == RG_CFG) begin
            o_x_rdata <= cfg_rdata;
         end else if (rg == RG_CSR) begin
            o_x_rdata <= csr_reg[csr_idx];
         end else begin
            o_x_rdata <= 8'h00;
         end
      end
   end

   // Program decode; an external MCU fetches nothing from us
   assign pgm_rom = !ext_reg && i_pgm_rd &&
                    ((!css && in_rng(i_pgm_addr, ROM_LO_BASE, ROM_SIZE)) ||
                     in_rng(i_pgm_addr, ROM_HI_BASE, ROM_SIZE));
   assign pgm_cram = !ext_reg && i_pgm_rd && css &&
                     in_rng(i_pgm_addr, CRAM_BASE, CRAM_SIZE);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pgm_rom_en <= 1'b0;
         o_pgm_cram_en <= 1'b0;
         o_pgm_mem_addr <= 13'h0000;
      end else begin
         o_pgm_rom_en <= pgm_rom;
         o_pgm_cram_en <= pgm_cram;
         o_pgm_mem_addr <= i_pgm_addr[12:0];
      end
   end

   // Internal data: separate strobes, never the external ports
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_iram_en <= 1'b0;
         o_sfr_en <= 1'b0;
         o_i_we <= 1'b0;
         o_i_addr <= 8'h00;
      end else begin
         o_iram_en <= (i_i_rd || i_i_wr) && !i_i_addr[7];
         // Indirect reach of the upper half is ignored
         o_sfr_en <= (i_i_rd || i_i_wr) && i_i_addr[7] && !i_i_indirect;
         // Write strobe passes as is; the enables pick the array
         o_i_we <= i_i_wr;
         o_i_addr <= i_i_addr;
      end
   end

   mmd_ep_cfg u_ep_cfg (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_mcu_wr(cfg_wr),
      .i_mcu_idx(cfg_idx),
      .i_mcu_wdata(i_x_wdata),
      .o_mcu_rdata(cfg_rdata),
      .i_ubm_wr(i_ubm_wr),
      .i_ubm_out(i_ubm_out),
      .i_ubm_ep(i_ubm_ep),
      .i_ubm_y(i_ubm_y),
      .i_ubm_count(i_ubm_count),
      .i_dma_wr(i_dma_wr),
      .i_dma_out(i_dma_out),
      .i_dma_ep(i_dma_ep),
      .i_dma_y(i_dma_y),
      .i_dma_count(i_dma_count),
      .i_view_out(i_view_out),
      .i_view_ep(i_view_ep),
      .o_view_cfg(o_view_cfg),
      .o_view_size(o_view_size),
      .o_view_x_count(o_view_x_count),
      .o_view_y_count(o_view_y_count),
      .o_view_x_addr(o_view_x_addr),
      .o_view_y_addr(o_view_y_addr),
      .o_view_iso(o_view_iso),
      .o_view_ring_len(o_view_ring_len)
   );

   // Checks below share one clock and the master reset
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_reset_boot: assert property (
      first_reg |-> !css && !o_cram_we)
      else $error("not in boot mode after reset");
   a_boot_rom_alias: assert property (
      (i_pgm_rd && !ext_reg && !css && i_pgm_addr[15:13] == 3'h4)
      |=> o_pgm_rom_en && !o_pgm_cram_en &&
      o_pgm_mem_addr == $past(i_pgm_addr[12:0]))
      else $error("boot ROM alias at 8000h not selected");
   a_boot_cram_write: assert property (
      (i_x_wr && !ext_reg && !css && i_x_addr < CRAM_SIZE)
      |=> o_cram_we && o_cram_wdata == $past(i_x_wdata))
      else $error("boot mode code RAM write lost");
   a_normal_fetch: assert property (
      (i_pgm_rd && !ext_reg && css && i_pgm_addr < CRAM_SIZE)
      |=> o_pgm_cram_en && !o_pgm_rom_en)
      else $error("normal fetch did not reach code RAM");
   a_cram_readonly: assert property (
      css && $past(css) |-> !o_cram_we)
      else $error("code RAM written in normal mode");
   a_indirect_upper: assert property (
      (i_i_rd && i_i_indirect && i_i_addr[7]) |=> !o_sfr_en && !o_iram_en)
      else $error("indirect access reached special registers");
   a_spaces_apart: assert property (
      (i_i_rd || i_i_wr) && !i_x_rd && !i_x_wr
      |=> !o_xram_we && !o_xram_re && !o_cram_we && !o_cram_re)
      else $error("internal access leaked to external space");
   a_ext_alias: assert property (
      (ext_reg && i_x_wr &&
      in_rng({EXT_HI_BITS, i_x_addr[10:0]}, BUF_BASE, BUF_SIZE))
      |=> o_xram_we && !o_xram_setup && !o_cram_we)
      else $error("external MCU alias missed the buffers");
   a_csr_readback: assert property (
      (i_x_wr && rg == RG_CSR) ##1
      (i_x_rd && rg == RG_CSR && !i_x_wr && csr_idx == $past(csr_idx))
      |=> o_x_rvalid && o_x_rdata == $past(i_x_wdata, 2))
      else $error("register window lost a write");

   a_normal_rom_hi: assert property (
      (i_pgm_rd && !ext_reg && css && i_pgm_addr[15:13] == 3'h4)
      |=> o_pgm_rom_en && !o_pgm_cram_en)
      else $error("boot ROM missing at 8000h in normal mode");
   a_sfr_direct: assert property (
      (i_i_rd || i_i_wr) && !i_i_indirect && i_i_addr[7]
      |=> o_sfr_en && !o_iram_en && o_i_addr == $past(i_i_addr))
      else $error("direct access missed special registers");
   a_lower_iram: assert property (
      (i_i_rd || i_i_wr) && !i_i_addr[7] |=> o_iram_en && !o_sfr_en)
      else $error("lower internal data not reached");
   a_ext_no_fetch: assert property (
      ext_reg && i_pgm_rd |=> !o_pgm_rom_en && !o_pgm_cram_en)
      else $error("external MCU mode fetched from us");
   a_ext_no_setup: assert property (
      ext_reg && (i_x_rd || i_x_wr)
      |=> !o_xram_setup && !o_cram_we && !o_cram_re)
      else $error("external MCU reached a hidden region");

   // Main scenarios the bench should reach
   c_boot_to_normal: cover property (!css ##1 css);
   c_indirect_refused: cover property (i_i_rd && i_i_indirect && i_i_addr[7]);
   c_ext_buf_write: cover property (ext_reg && o_xram_we);
   c_cfg_read: cover property (o_x_rvalid && $past(rg == RG_CFG));
   c_dropped_write: cover property (css && i_x_wr && i_x_addr < CRAM_SIZE);
endmodule : mmd_decoder

// ==== src/mmd_pkg.sv ====
// Purpose: Constants and types for the MCU memory map decoder.
// Assumes: One 50 MHz clock, byte-wide data spaces.
// Notes: Bases below are full 16-bit addresses, the ROM ones in program space; block offsets are 3-bit.
package mmd_pkg;
   localparam logic [15:0] ROM_LO_BASE = 16'h0000;
   localparam logic [15:0] ROM_HI_BASE = 16'h8000;
   localparam logic [15:0] ROM_SIZE = 16'h2000;
   localparam logic [15:0] CRAM_BASE = 16'h0000;
   localparam logic [15:0] CRAM_SIZE = 16'h1800;
   localparam logic [15:0] BUF_BASE = 16'hfa10;
   localparam logic [15:0] BUF_SIZE = 16'h0518;
   localparam logic [15:0] SETUP_BASE = 16'hff28;
   localparam logic [15:0] SETUP_SIZE = 16'h0008;
   localparam logic [15:0] CFG_BASE = 16'hff30;
   localparam logic [15:0] CFG_SIZE = 16'h0080;
   localparam logic [15:0] CSR_BASE = 16'hffb0;
   localparam logic [15:0] CSR_SIZE = 16'h0050;
   localparam logic [15:0] FAMILY_BASE = 16'hf800;
   localparam logic [4:0] EXT_HI_BITS = 5'h1f;
   localparam int CSR_BYTES = 80;
   localparam logic [6:0] CSR_MEMCFG_IDX = 7'h00;
   localparam int CSS_BIT = 0;
   localparam int EP_BLOCKS = 16;
   localparam int CFG_BYTES = 128;
   localparam logic [2:0] OFS_CFG = 3'h0;
   localparam logic [2:0] OFS_BBAX = 3'h1;
   localparam logic [2:0] OFS_BSIZ = 3'h2;
   localparam logic [2:0] OFS_CNTX = 3'h3;
   localparam logic [2:0] OFS_BBAY = 3'h5;
   localparam logic [2:0] OFS_CNTY = 3'h7;
   localparam int ISO_BIT = 6;

   typedef enum logic [2:0] {
      RG_NONE = 3'b000,
      RG_CRAM = 3'b001,
      RG_BUF = 3'b010,
      RG_SETUP = 3'b011,
      RG_CFG = 3'b100,
      RG_CSR = 3'b101
   } mmd_region_type;

   function automatic logic in_rng(input logic [15:0] a,
                                   input logic [15:0] base,
                                   input logic [15:0] size);
      logic [16:0] top;
      top = {1'b0, base} + {1'b0, size};
      in_rng = (a >= base) && ({1'b0, a} < top);
   endfunction : in_rng
endpackage : mmd_pkg

// ==== src/mmd_ep_cfg.sv ====
// Purpose: Endpoint configuration blocks with three-way shared access.
// Assumes: Blocks 0-7 are IN endpoints 7..0, 8-15 are OUT endpoints 7..0.
// Notes: Same-byte collisions resolve buffer manager, then DMA, then MCU.
`timescale 1ns/1ps
module mmd_ep_cfg (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // MCU byte port
   input wire logic i_mcu_wr,
   input wire logic [6:0] i_mcu_idx,
   input wire logic [7:0] i_mcu_wdata,
   output logic [7:0] o_mcu_rdata,
   // Buffer manager count port
   input wire logic i_ubm_wr,
   input wire logic i_ubm_out,
   input wire logic [2:0] i_ubm_ep,
   input wire logic i_ubm_y,
   input wire logic [7:0] i_ubm_count,
   // DMA count port
   input wire logic i_dma_wr,
   input wire logic i_dma_out,
   input wire logic [2:0] i_dma_ep,
   input wire logic i_dma_y,
   input wire logic [7:0] i_dma_count,
   // Endpoint view
   input wire logic i_view_out,
   input wire logic [2:0] i_view_ep,
   output logic [7:0] o_view_cfg,
   output logic [7:0] o_view_size,
   output logic [7:0] o_view_x_count,
   output logic [7:0] o_view_y_count,
   output logic [15:0] o_view_x_addr,
   output logic [15:0] o_view_y_addr,
   output logic o_view_iso,
   output logic [7:0] o_view_ring_len
);
   import mmd_pkg::*;

   logic [7:0] mem_reg [CFG_BYTES];
   logic [6:0] ubm_idx;
   logic [6:0] dma_idx;
   logic [6:0] vb;
   logic ubm_ok;
   logic dma_ok;

   function automatic logic [3:0] blk_of(input logic out,
                                         input logic [2:0] ep);
      blk_of = out ? (4'd15 - {1'b0, ep}) : (4'd7 - {1'b0, ep});
   endfunction : blk_of

   function automatic logic [15:0] phys(input logic [7:0] base);
      phys = FAMILY_BASE + {5'h00, base, 3'h0};
   endfunction : phys

   assign ubm_idx = {blk_of(i_ubm_out, i_ubm_ep),
                     i_ubm_y ? OFS_CNTY : OFS_CNTX};
   assign dma_idx = {blk_of(i_dma_out, i_dma_ep),
                     i_dma_y ? OFS_CNTY : OFS_CNTX};
   assign ubm_ok = i_ubm_wr && !i_ubm_out;
   assign dma_ok = i_dma_wr && i_dma_out;
   assign vb = {blk_of(i_view_out, i_view_ep), 3'h0};
   assign o_mcu_rdata = mem_reg[i_mcu_idx];

   // Shared storage, one write per byte per cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < CFG_BYTES; i++) begin
            mem_reg[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < CFG_BYTES; i++) begin
            if (ubm_ok && ubm_idx == 7'(i)) begin
               mem_reg[i] <= i_ubm_count;
            end else if (dma_ok && dma_idx == 7'(i)) begin
               mem_reg[i] <= i_dma_count;
            end else if (i_mcu_wr && i_mcu_idx == 7'(i)) begin
               mem_reg[i] <= i_mcu_wdata;
            end
         end
      end
   end

   // Registered endpoint view for the pipe logic
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_view_cfg <= 8'h00;
         o_view_size <= 8'h00;
         o_view_x_count <= 8'h00;
         o_view_y_count <= 8'h00;
         // Reset shows where an all-zero base byte points
         o_view_x_addr <= FAMILY_BASE;
         o_view_y_addr <= FAMILY_BASE;
         o_view_iso <= 1'b0;
         o_view_ring_len <= 8'h00;
      end else begin
         o_view_cfg <= mem_reg[vb | 7'(OFS_CFG)];
         o_view_size <= mem_reg[vb | 7'(OFS_BSIZ)];
         // Counts are samples per transaction here
         o_view_x_count <= mem_reg[vb | 7'(OFS_CNTX)];
         o_view_y_count <= mem_reg[vb | 7'(OFS_CNTY)];
         o_view_x_addr <= phys(mem_reg[vb | 7'(OFS_BBAX)]);
         o_view_iso <= mem_reg[vb | 7'(OFS_CFG)][ISO_BIT];
         // One circular buffer: Y collapses onto X
         if (mem_reg[vb | 7'(OFS_CFG)][ISO_BIT]) begin
            o_view_y_addr <= phys(mem_reg[vb | 7'(OFS_BBAX)]);
            o_view_ring_len <= mem_reg[vb | 7'(OFS_BSIZ)];
         end else begin
            o_view_y_addr <= phys(mem_reg[vb | 7'(OFS_BBAY)]);
            o_view_ring_len <= 8'h00;
         end
      end
   end

   a_ubm_out_ignored: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ubm_wr && i_ubm_out && !i_dma_wr && !i_mcu_wr)
      |=> mem_reg[$past(ubm_idx)] == $past(mem_reg[ubm_idx]))
      else $error("buffer manager wrote an OUT count");
   a_addr_formula: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      o_view_x_addr[2:0] == 3'h0 && o_view_x_addr >= FAMILY_BASE)
      else $error("buffer address not aligned or below base");
   a_iso_single_ring: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      o_view_iso |-> o_view_y_addr == o_view_x_addr)
      else $error("iso endpoint shows two buffers");
endmodule : mmd_ep_cfg

// ==== testbench/mmd_cram_model.sv ====
// Purpose: Code RAM array model behind the decoder data port.
// Assumes: 6K bytes; only write strobes matter.
// Notes: Keeps what arrives, so dropped writes show as unchanged bytes.
`timescale 1ns/1ps
module mmd_cram_model (
   // Clock
   input wire logic i_clk,
   // Write port from the decoder
   input wire logic i_we,
   input wire logic [12:0] i_addr,
   input wire logic [7:0] i_wdata,
   // Probe for the bench
   input wire logic [12:0] i_probe_addr,
   output logic [7:0] o_probe_data
);
   logic [7:0] mem_reg [0:6143];
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_reg[i_addr] <= i_wdata;
      end
   end
   assign o_probe_data = mem_reg[i_probe_addr];
endmodule : mmd_cram_model

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the memory map decoder.
// Assumes: Strobes stand one cycle, so they are read right after a task.
// Notes: Expected values come from the map, not from the design.
`timescale 1ns/1ps
module tb_top;
   import mmd_pkg::*;
   logic i_clk = '0, i_rst_n = '0, i_ext_mcu_pin = '0, i_pgm_rd = '0;
   logic i_x_rd = '0, i_x_wr = '0, i_i_rd = '0, i_i_wr = '0;
   logic i_i_indirect = '0, i_ubm_wr = '0, i_ubm_out = '0, i_ubm_y = '0;
   logic i_dma_wr = '0, i_dma_out = '0, i_dma_y = '0, i_view_out = '0;
   logic [15:0] i_pgm_addr = '0, i_x_addr = '0;
   logic [7:0] i_x_wdata = '0, i_i_addr = '0;
   logic [7:0] i_ubm_count = '0, i_dma_count = '0;
   logic [2:0] i_ubm_ep = '0, i_dma_ep = '0, i_view_ep = '0;
   logic o_pgm_rom_en, o_pgm_cram_en, o_x_rvalid, o_cram_we, o_xram_we;
   logic o_xram_setup, o_iram_en, o_sfr_en, o_view_iso;
   logic o_cram_re, o_xram_re, o_i_we;
   logic o_code_space_select, o_ext_mode;
   logic [12:0] o_pgm_mem_addr, o_cram_addr;
   logic [7:0] o_x_rdata, o_cram_wdata, o_view_x_count, o_view_y_count;
   logic [7:0] o_view_ring_len, probe;
   logic [7:0] o_xram_wdata, o_i_addr, o_view_cfg, o_view_size;
   logic [15:0] xram_word;
   logic [10:0] o_xram_addr;
   logic [15:0] o_view_x_addr, o_view_y_addr;
   int fails = 0, comparisons = 0;

   mmd_decoder u_mmd_decoder (.i_clk, .i_rst_n, .i_ext_mcu_pin, .i_pgm_rd,
      .i_pgm_addr, .o_pgm_rom_en, .o_pgm_cram_en, .o_pgm_mem_addr, .i_x_rd,
      .i_x_wr, .i_x_addr, .i_x_wdata, .o_x_rdata, .o_x_rvalid, .o_cram_we,
      .o_cram_re, .o_cram_addr, .o_cram_wdata, .o_xram_we, .o_xram_re,
      .o_xram_setup, .o_xram_addr, .o_xram_wdata, .i_i_rd, .i_i_wr,
      .i_i_indirect, .i_i_addr, .o_iram_en, .o_sfr_en, .o_i_we,
      .o_i_addr, .i_ubm_wr, .i_ubm_out, .i_ubm_ep, .i_ubm_y, .i_ubm_count,
      .i_dma_wr, .i_dma_out, .i_dma_ep, .i_dma_y, .i_dma_count, .i_view_out,
      .i_view_ep, .o_view_cfg, .o_view_size, .o_view_x_count,
      .o_view_y_count, .o_view_x_addr, .o_view_y_addr, .o_view_iso,
      .o_view_ring_len, .o_code_space_select, .o_ext_mode);
   mmd_cram_model u_mmd_cram_model (.i_clk, .i_we(o_cram_we),
      .i_addr(o_cram_addr), .i_wdata(o_cram_wdata),
      .i_probe_addr(13'h0010), .o_probe_data(probe));
   assign xram_word = {4'(o_xram_we), 1'(o_xram_setup), o_xram_addr};

   always #10 i_clk = ~i_clk;

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic print_verdict;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic fetch(input logic [15:0] a);
      @(posedge i_clk);
      i_pgm_rd <= 1'b1;
      i_pgm_addr <= a;
      @(posedge i_clk);
      i_pgm_rd <= 1'b0;
      #1;
   endtask : fetch

   task automatic xacc(input logic wr, input logic [15:0] a,
                       input logic [7:0] d);
      @(posedge i_clk);
      i_x_wr <= wr;
      i_x_rd <= ~wr;
      i_x_addr <= a;
      i_x_wdata <= d;
      @(posedge i_clk);
      i_x_wr <= 1'b0;
      i_x_rd <= 1'b0;
      #1;
   endtask : xacc

   task automatic iacc(input logic ind, input logic [7:0] a);
      @(posedge i_clk);
      i_i_rd <= 1'b1;
      i_i_indirect <= ind;
      i_i_addr <= a;
      @(posedge i_clk);
      i_i_rd <= 1'b0;
      #1;
   endtask : iacc

   // Both count ports see the same fields; only one strobe rises
   task automatic cnt(input logic usb_buffer_manager, input logic out, input logic [2:0] ep,
                      input logic y, input logic [7:0] c);
      @(posedge i_clk);
      i_ubm_wr <= usb_buffer_manager;
      i_dma_wr <= ~usb_buffer_manager;
      {i_ubm_out, i_ubm_ep, i_ubm_y, i_ubm_count} <= {out, ep, y, c};
      {i_dma_out, i_dma_ep, i_dma_y, i_dma_count} <= {out, ep, y, c};
      @(posedge i_clk);
      i_ubm_wr <= 1'b0;
      i_dma_wr <= 1'b0;
   endtask : cnt

   task automatic view(input logic out, input logic [2:0] ep);
      @(posedge i_clk);
      i_view_out <= out;
      i_view_ep <= ep;
      repeat (2) @(posedge i_clk);
      #1;
   endtask : view

   task automatic t_reset;
      i_rst_n <= 1'b0;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      #1;
      chk("select", 16'h0000, 16'(o_code_space_select));
   endtask : t_reset

   task automatic t_boot;
      fetch(16'h0005);
      chk("rom_lo", 16'h0001, 16'(o_pgm_rom_en));
      chk("pgm_addr", 16'h0005, 16'(o_pgm_mem_addr));
      fetch(16'h8005);
      chk("rom_hi", 16'h0001, 16'(o_pgm_rom_en));
      xacc(1'b1, 16'h0010, 8'ha5);
      chk("cram_we", 16'h0001, 16'(o_cram_we));
      chk("cram_addr", 16'h0010, 16'(o_cram_addr));
      xacc(1'b0, 16'h0010, 8'h00);
      chk("cram_re", 16'h0001, 16'(o_cram_re));
   endtask : t_boot

   task automatic t_normal;
      xacc(1'b1, CSR_BASE, 8'h01);
      chk("select", 16'h0001, 16'(o_code_space_select));
      fetch(16'h0005);
      chk("cram_fetch", 16'h0001, 16'(o_pgm_cram_en));
      chk("rom_off", 16'h0000, 16'(o_pgm_rom_en));
      fetch(16'h8005);
      chk("rom_hi", 16'h0001, 16'(o_pgm_rom_en));
      xacc(1'b1, 16'h0010, 8'h5a);
      chk("ro_we", 16'h0000, 16'(o_cram_we));
      @(posedge i_clk);
      #1;
      chk("ro_keep", 16'h00a5, 16'(probe));
      xacc(1'b0, CSR_BASE, 8'h00);
      chk("csr_rd", 16'h0101, {8'(o_x_rvalid), o_x_rdata});
   endtask : t_normal

   task automatic t_xram;
      xacc(1'b1, 16'hfa60, 8'h11);
      chk("buf", 16'h1050, xram_word);
      chk("buf_data", 16'h0011, 16'(o_xram_wdata));
      xacc(1'b1, 16'hff29, 8'h22);
      chk("setup", 16'h1801, xram_word);
      xacc(1'b0, 16'hff29, 8'h00);
      chk("setup_rd", 16'h0101, {8'(o_xram_re), 8'(o_xram_setup)});
   endtask : t_xram

   task automatic t_idata;
      iacc(1'b0, 8'h90);
      chk("sfr_dir", 16'h0100, {8'(o_sfr_en), 8'(o_iram_en)});
      chk("i_addr", 16'h0090, {8'(o_i_we), o_i_addr});
      iacc(1'b1, 8'h90);
      chk("sfr_ind", 16'h0000, {8'(o_sfr_en), 8'(o_iram_en)});
      iacc(1'b1, 8'h10);
      chk("ram_ind", 16'h0001, {8'(o_sfr_en), 8'(o_iram_en)});
      chk("no_x", 16'h0000, {8'(o_cram_we), 8'(o_xram_we)});
   endtask : t_idata

   task automatic t_cfg;
      xacc(1'b1, 16'hff51, 8'h4c);
      xacc(1'b1, 16'hff52, 8'h20);
      cnt(1'b1, 1'b0, 3'h3, 1'b0, 8'h40);
      cnt(1'b0, 1'b0, 3'h3, 1'b0, 8'h77);
      view(1'b0, 3'h3);
      chk("x_addr", 16'hfa60, o_view_x_addr);
      chk("x_count", 16'h0040, 16'(o_view_x_count));
      chk("ring0", 16'h0000, {8'(o_view_iso), o_view_ring_len});
      xacc(1'b1, 16'hff50, 8'h40);
      view(1'b0, 3'h3);
      chk("ring", 16'h0120, {8'(o_view_iso), o_view_ring_len});
      chk("cfg", 16'h0040, 16'(o_view_cfg));
      chk("size", 16'h0020, 16'(o_view_size));
      chk("y_addr", 16'hfa60, o_view_y_addr);
      cnt(1'b0, 1'b1, 3'h0, 1'b1, 8'h33);
      cnt(1'b1, 1'b1, 3'h0, 1'b1, 8'h55);
      view(1'b1, 3'h0);
      chk("y_count", 16'h0033, 16'(o_view_y_count));
      xacc(1'b1, 16'hffaf, 8'h44);
      view(1'b1, 3'h0);
      chk("mcu_count", 16'h0044, 16'(o_view_y_count));
      xacc(1'b0, 16'hffaf, 8'h00);
      chk("cfg_rd", 16'h0144, {8'(o_x_rvalid), o_x_rdata});
   endtask : t_cfg

   // The strap only ever asks for aliased bus addresses
   task automatic t_ext;
      @(posedge i_clk);
      i_ext_mcu_pin <= 1'b1;
      repeat (6) @(posedge i_clk);
      xacc(1'b0, 16'h07b0, 8'h00);
      chk("alias_lo", 16'h0101, {8'(o_x_rvalid), o_x_rdata});
      xacc(1'b0, 16'h37b0, 8'h00);
      chk("alias_hi", 16'h0101, {8'(o_x_rvalid), o_x_rdata});
      xacc(1'b1, 16'h0260, 8'h66);
      chk("alias_buf", 16'h1050, xram_word);
      fetch(16'h0005);
      chk("no_fetch", 16'h0000, 16'({o_pgm_rom_en, o_pgm_cram_en}));
      i_ext_mcu_pin <= 1'b0;
   endtask : t_ext

   initial begin
      t_reset();
      t_boot();
      t_normal();
      t_xram();
      t_idata();
      t_cfg();
      t_ext();
      t_reset();
      print_verdict();
   end

   // Whole run is about 120 cycles
   initial begin
      #100000;
      fails++;
      print_verdict();
   end
endmodule : tb_top
